// [hdl/mfa_multiply_float_arith_unit.sv]
// Function
// - divide double accumulator by index two, quotient in primary, remainder in secondary
// - trap when divisor magnitude is not above primary magnitude
// - signed product of primary and index two fills double accumulator
// - product lsb lands at secondary position count minus one
// - last secondary bit stays zero; counts above twenty-three lose significance
// - missing count means twenty-three
// - primary bit zero holds true product sign, extension bits equal it
// - multiply traps when primary holds most negative value
// - floating first operand and result in primary plus index one
// - floating second operand from index two and three
// - floating results normalized except unnormalized add
// - trap on unrepresentable exponent or most negative made positive
// - on trap pointer holds next sequential instruction address
// - float add sum to primary, sign of larger operand
// - add and subtract put larger-exponent fraction in index two, garbage in secondary
// - zero larger-exponent fraction returns the other operand
// - unnormalized add equals add without normalization
// - subtract complements second operand then adds
// - float multiply fraction in primary and secondary, exponent in index one
`timescale 1ns/1ps
`default_nettype none
module mfa_multiply_float_arith_unit (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic start,
  input wire mfa_pkg::mfa_req_t req,
  output logic busy,
  output logic done,
  output logic trap,
  output logic [7:0] trap_location,
  output var mfa_pkg::mfa_res_t res
);
  import mfa_pkg::*;

  typedef enum logic {st_idle, st_exec} mfa_state_t;

  mfa_state_t state_r;
  mfa_req_t req_r;
  mfa_res_t res_nxt;
  logic trap_nxt;

  function automatic logic [24:0] mag(input logic [23:0] x);
    mag = x[23] ? (25'h0 - {1'b1, x}) : {1'b0, x};
  endfunction

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      state_r <= st_idle;
    else if (ce)
    begin
      unique case (state_r)
        st_idle: if (start) state_r <= st_exec;
        st_exec: state_r <= st_idle;
      endcase
    end
  end

  // operands are latched once; the sequencer may change them afterwards
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      req_r <= '0;
    else if (ce && (state_r == st_idle) && start)
      req_r <= req;
  end

  logic [47:0] prod;
  mfa_multiply #(.W(WORD_W)) u_mul (
    .a(req_r.primary_accumulator),
    .b(req_r.index_reg_two),
    .p(prod)
  );

  // integer multiply
  logic [4:0] cnt;
  logic [47:0] mpy_dbl;
  logic mpy_trap;
  always_comb
  begin
    cnt = req_r.count_given ? req_r.count : COUNT_DEFAULT;
    if (cnt <= COUNT_ALIGN)
      mpy_dbl = prod << (COUNT_ALIGN - cnt);
    else
      mpy_dbl = $signed(prod) >>> (cnt - COUNT_ALIGN);
    mpy_dbl[0] = 1'b0;
    mpy_dbl[47] = prod[47];
    mpy_trap = req_r.primary_accumulator == MOST_NEG;
  end

  // integer divide
  logic [4:0] dcnt;
  logic signed [46:0] dvd;
  logic signed [46:0] dvs;
  logic signed [46:0] quo;
  logic signed [46:0] rem;
  logic div_trap;
  always_comb
  begin
    dcnt = (cnt > COUNT_MAX) ? COUNT_MAX : cnt;
    div_trap = mag(req_r.index_reg_two) <= mag(req_r.primary_accumulator);
    dvd = {req_r.primary_accumulator, req_r.secondary_accumulator[23:1]};
    dvd = dvd >>> (COUNT_MAX - dcnt);
    // a trapped divide never divides by zero
    dvs = div_trap ? 47'sh1 : {{23{req_r.index_reg_two[23]}}, req_r.index_reg_two};
    quo = dvd / dvs;
    rem = dvd % dvs;
  end

  // floating add family
  logic is_fsb;
  logic [23:0] fb;
  logic sub_trap;
  logic a_big;
  logic [23:0] big_f;
  logic [23:0] small_f;
  logic [23:0] big_e;
  logic [23:0] small_e;
  logic [24:0] ediff;
  logic [23:0] aligned;
  logic [24:0] sum25;
  logic [23:0] add_f;
  logic [25:0] add_e;
  always_comb
  begin
    is_fsb = req_r.op == op_float_subtract;
    fb = is_fsb ? (24'h0 - req_r.index_reg_two) : req_r.index_reg_two;
    sub_trap = is_fsb && (req_r.index_reg_two == MOST_NEG);
    a_big = $signed(req_r.index_reg_one) >= $signed(req_r.index_reg_three);
    big_f = a_big ? req_r.primary_accumulator : fb;
    small_f = a_big ? fb : req_r.primary_accumulator;
    big_e = a_big ? req_r.index_reg_one : req_r.index_reg_three;
    small_e = a_big ? req_r.index_reg_three : req_r.index_reg_one;
    ediff = {big_e[23], big_e} - {small_e[23], small_e};
    if (ediff >= ALIGN_LIMIT)
      aligned = {24{small_f[23]}};
    else
      aligned = $signed(small_f) >>> ediff[4:0];
    sum25 = {big_f[23], big_f} + {aligned[23], aligned};
    if (big_f == '0)
    begin
      add_f = small_f;
      add_e = {{2{small_e[23]}}, small_e};
    end
    else if (sum25[24] != sum25[23])
    begin
      add_f = sum25[24:1];
      add_e = {{2{big_e[23]}}, big_e} + 26'h1;
    end
    else
    begin
      add_f = sum25[23:0];
      add_e = {{2{big_e[23]}}, big_e};
    end
  end

  // floating multiply and shared normalizer
  logic is_fmp;
  logic [47:0] mul_f;
  logic [25:0] mul_e;
  logic fmp_trap;
  logic [47:0] n_in;
  logic [25:0] n_ein;
  logic [47:0] n_f;
  logic [25:0] n_e;
  always_comb
  begin
    is_fmp = req_r.op == op_float_multiply;
    mul_f = {prod[46:0], 1'b0};
    mul_e = {{2{req_r.index_reg_one[23]}}, req_r.index_reg_one}
          + {{2{req_r.index_reg_three[23]}}, req_r.index_reg_three};
    fmp_trap = (req_r.primary_accumulator == MOST_NEG) && (req_r.index_reg_two == MOST_NEG);
    n_in = is_fmp ? mul_f : {add_f, 24'h0};
    n_ein = is_fmp ? mul_e : add_e;
  end

  mfa_normalize #(.W(2 * WORD_W), .EW(WORD_W + 2)) u_norm (
    .frac_in(n_in),
    .exp_in(n_ein),
    .frac_out(n_f),
    .exp_out(n_e)
  );

  logic [25:0] f_e;
  logic exp_trap;
  always_comb
  begin
    f_e = (req_r.op == op_float_add_unnormalized) ? add_e : n_e;
    exp_trap = (f_e[25:23] != 3'h0) && (f_e[25:23] != 3'h7);
    res_nxt.index_reg_one = req_r.index_reg_one;
    res_nxt.index_reg_two = req_r.index_reg_two;
    res_nxt.index_reg_three = req_r.index_reg_three;
    res_nxt.primary_accumulator = req_r.primary_accumulator;
    res_nxt.secondary_accumulator = req_r.secondary_accumulator;
    res_nxt.program_pointer = req_r.next_pointer;
    trap_nxt = 1'b0;
    case (req_r.op)
      op_integer_multiply:
      begin
        res_nxt.primary_accumulator = mpy_dbl[47:24];
        res_nxt.secondary_accumulator = mpy_dbl[23:0];
        trap_nxt = mpy_trap;
      end
      op_integer_divide:
      begin
        res_nxt.primary_accumulator = quo[23:0];
        res_nxt.secondary_accumulator = rem[23:0];
        trap_nxt = div_trap;
      end
      op_float_add, op_float_subtract:
      begin
        res_nxt.primary_accumulator = n_f[47:24];
        res_nxt.index_reg_one = f_e[23:0];
        res_nxt.index_reg_two = big_f;
        res_nxt.secondary_accumulator = aligned;
        trap_nxt = exp_trap || sub_trap;
      end
      op_float_add_unnormalized:
      begin
        res_nxt.primary_accumulator = add_f;
        res_nxt.index_reg_one = f_e[23:0];
        res_nxt.index_reg_two = big_f;
        res_nxt.secondary_accumulator = aligned;
        trap_nxt = exp_trap;
      end
      op_float_multiply:
      begin
        res_nxt.primary_accumulator = n_f[47:24];
        res_nxt.secondary_accumulator = n_f[23:0];
        res_nxt.index_reg_one = f_e[23:0];
        trap_nxt = exp_trap || fmp_trap;
      end
      default:
        trap_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      busy <= (state_r == st_idle) && start;
      done <= state_r == st_exec;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      res <= '0;
      trap <= 1'b0;
      trap_location <= TRAP_LOCATION;
    end
    else if (ce)
    begin
      trap_location <= TRAP_LOCATION;
      trap <= (state_r == st_exec) && trap_nxt;
      if (state_r == st_exec)
        res <= res_nxt;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset || !ce);

  property p_latency;
    (state_r == st_idle) && start |=> busy ##1 (done && !busy);
  endproperty
  a_latency: assert property (p_latency) else $error("completion not two edges after start");

  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  property p_mpy_trap;
    done && (req_r.op == op_integer_multiply) |-> trap == (req_r.primary_accumulator == MOST_NEG);
  endproperty
  a_mpy_trap: assert property (p_mpy_trap) else $error("multiply trap wrong");

  property p_mpy_value;
    done && (req_r.op == op_integer_multiply) && !trap && !req_r.count_given |->
      $signed({res.primary_accumulator, res.secondary_accumulator}) ==
      48'sh2 * ($signed(req_r.primary_accumulator) * $signed(req_r.index_reg_two));
  endproperty
  a_mpy_value: assert property (p_mpy_value) else $error("default count product wrong");

  property p_mpy_lsb;
    done && (req_r.op == op_integer_multiply) |-> !res.secondary_accumulator[0];
  endproperty
  a_mpy_lsb: assert property (p_mpy_lsb) else $error("secondary last bit not zero");

  property p_mpy_sign;
    done && (req_r.op == op_integer_multiply) && !trap && (req_r.primary_accumulator != '0)
      && (req_r.index_reg_two != '0) |-> res.primary_accumulator[23] ==
      (req_r.primary_accumulator[23] ^ req_r.index_reg_two[23]);
  endproperty
  a_mpy_sign: assert property (p_mpy_sign) else $error("product sign wrong");

  property p_norm;
    done && !trap && (res.primary_accumulator != '0) && ((req_r.op == op_float_add)
      || (req_r.op == op_float_subtract) || (req_r.op == op_float_multiply)) |->
      res.primary_accumulator[23] != res.primary_accumulator[22];
  endproperty
  a_norm: assert property (p_norm) else $error("float result not normalized");

  property p_fad_x2;
    done && (req_r.op == op_float_add) && !trap &&
      ($signed(req_r.index_reg_one) > $signed(req_r.index_reg_three)) |->
      res.index_reg_two == req_r.primary_accumulator;
  endproperty
  a_fad_x2: assert property (p_fad_x2) else $error("index two not larger fraction");

  property p_ptr;
    done |-> res.program_pointer == req_r.next_pointer;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not next instruction");

  property p_div_trap;
    done && (req_r.op == op_integer_divide) |->
      trap == (mag(req_r.index_reg_two) <= mag(req_r.primary_accumulator));
  endproperty
  a_div_trap: assert property (p_div_trap) else $error("divide trap wrong");
endmodule // mfa_multiply_float_arith_unit
`default_nettype wire

// [hdl/mfa_pkg.sv]
`default_nettype none
package mfa_pkg;
  localparam int WORD_W = 24;
  localparam int PTR_W = 16;
  // most negative word, octal 40000000
  localparam logic [23:0] MOST_NEG = 24'h800000;
  localparam logic [4:0] COUNT_DEFAULT = 5'h17;
  localparam logic [4:0] COUNT_MAX = 5'h17;
  // count at which the product fills the double register unshifted
  localparam logic [4:0] COUNT_ALIGN = 5'h18;
  localparam logic [24:0] ALIGN_LIMIT = 25'h0000018;
  // trap location, octal 41
  localparam logic [7:0] TRAP_LOCATION = 8'h21;

  typedef enum logic [2:0] {
    op_none = 3'h0,
    op_integer_multiply = 3'h1,
    op_integer_divide = 3'h2,
    op_float_add = 3'h3,
    op_float_add_unnormalized = 3'h4,
    op_float_subtract = 3'h5,
    op_float_multiply = 3'h6,
    op_float_divide = 3'h7
  } mfa_op_t;

  typedef struct packed {
    mfa_op_t op;
    logic count_given;
    logic [4:0] count;
    logic [23:0] primary_accumulator;
    logic [23:0] secondary_accumulator;
    logic [23:0] index_reg_one;
    logic [23:0] index_reg_two;
    logic [23:0] index_reg_three;
    logic [15:0] next_pointer;
  } mfa_req_t;

  typedef struct packed {
    logic [23:0] primary_accumulator;
    logic [23:0] secondary_accumulator;
    logic [23:0] index_reg_one;
    logic [23:0] index_reg_two;
    logic [23:0] index_reg_three;
    logic [15:0] program_pointer;
  } mfa_res_t;
endpackage
`default_nettype wire

// [hdl/mfa_multiply.sv]
`timescale 1ns/1ps
`default_nettype none
module mfa_multiply #(
  parameter int W = 24
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [2*W-1:0] p
);
  logic signed [2*W-1:0] prod;
  always_comb
  begin
    prod = $signed(a) * $signed(b);
    p = prod;
  end
endmodule // mfa_multiply
`default_nettype wire

// [hdl/mfa_normalize.sv]
`timescale 1ns/1ps
`default_nettype none
module mfa_normalize #(
  parameter int W = 48,
  parameter int EW = 26
) (
  input wire logic [W-1:0] frac_in,
  input wire logic [EW-1:0] exp_in,
  output logic [W-1:0] frac_out,
  output logic [EW-1:0] exp_out
);
  logic [$clog2(W)-1:0] sh;
  logic run;
  always_comb
  begin
    sh = '0;
    run = 1'b1;
    // count leading copies of the sign below the sign bit
    for (int i = W - 2; i >= 0; i--)
    begin
      if (run && (frac_in[i] == frac_in[W-1]))
        sh = sh + 1'b1;
      else
        run = 1'b0;
    end
    frac_out = frac_in << sh;
    if (frac_in == '0)
      exp_out = '0;
    else
      exp_out = exp_in - EW'(sh);
  end
endmodule // mfa_normalize
`default_nettype wire

// [dv/mfa_seq_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mfa_seq_model (
  input wire logic sys_clk,
  input wire logic ce,
  input wire logic go,
  input wire mfa_pkg::mfa_req_t req_in,
  input wire logic busy,
  input wire logic done,
  input wire logic trap,
  input wire mfa_pkg::mfa_res_t res,
  output logic start,
  output var mfa_pkg::mfa_req_t req,
  output logic fin,
  output logic trap_q,
  output var mfa_pkg::mfa_res_t res_q,
  output int lat
);
  import mfa_pkg::*;
  logic taken;
  initial
  begin
    start = 1'b0;
    req = '0;
    fin = 1'b0;
    taken = 1'b0;
    lat = 0;
  end
  always @(posedge sys_clk)
  begin
    if (go)
    begin
      start <= 1'b1;
      req <= req_in;
      fin <= 1'b0;
      taken <= 1'b0;
      lat <= 0;
    end
    else if (start && ce && !busy)
    begin
      start <= 1'b0;
      taken <= 1'b1;
    end
    else if (taken && done)
    begin
      res_q <= res;
      trap_q <= trap;
      fin <= 1'b1;
      // the edge that sees done closes the count
      lat <= lat + 1;
      taken <= 1'b0;
      req <= ~req; // released lines must not keep last value
    end
    else if (taken && ce)
      lat <= lat + 1;
  end
endmodule // mfa_seq_model
`default_nettype wire

// [dv/mfa_multiply_float_arith_unit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mfa_multiply_float_arith_unit_tb;
  import mfa_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic ce_rand = 1'b0;
  logic go = 1'b0;
  logic start, busy, done, trap, fin, trap_q;
  logic [7:0] trap_location;
  mfa_req_t req_in = '0;
  mfa_req_t req;
  mfa_res_t res, res_q;
  int lat;
  int bad_count = 0;
  int n_compared = 0;
  logic [31:0] lfsr_r = 32'hb078;
  logic [31:0] ce_s = 32'hb078;
  logic [47:0] dbl;
  logic [71:0] flt;
  assign dbl = {res_q.primary_accumulator, res_q.secondary_accumulator};
  assign flt = {res_q.primary_accumulator, res_q.index_reg_one, res_q.index_reg_two};

  always #12.5 sys_clk = ~sys_clk;

  mfa_multiply_float_arith_unit i_mfa_multiply_float_arith_unit (
    .sys_clk(sys_clk), .reset(reset), .ce(ce), .start(start), .req(req), .busy(busy),
    .done(done), .trap(trap), .trap_location(trap_location), .res(res));

  mfa_seq_model i_mfa_seq_model (
    .sys_clk(sys_clk), .ce(ce), .go(go), .req_in(req_in), .busy(busy), .done(done),
    .trap(trap), .res(res), .start(start), .req(req), .fin(fin), .trap_q(trap_q),
    .res_q(res_q), .lat(lat));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected double register after a multiply
  function automatic logic [47:0] mul_exp(input logic [23:0] a, b, input logic cg,
      input logic [4:0] c);
    logic [47:0] p;
    logic [47:0] q;
    logic [5:0] n;
    p = {{24{a[23]}}, a} * {{24{b[23]}}, b};
    n = cg ? {1'b0, c} : 6'h17;
    if (n <= 6'h18)
      q = p << (6'h18 - n);
    else
      q = $signed(p) >>> (n - 6'h18);
    q[0] = 1'b0;
    q[47] = p[47];
    return q;
  endfunction

  always @(posedge sys_clk)
  begin
    ce_s <= lfsr_next(ce_s);
    ce <= !ce_rand || ce_s[3] || ce_s[7];
  end

  task rnd(output logic [31:0] v);
    repeat (16) lfsr_r = lfsr_next(lfsr_r);
    v = lfsr_r;
  endtask

  task chk(input string nm, input logic [71:0] e, input logic [71:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic go_op(input mfa_op_t op, input logic cg, input logic [4:0] c,
      input logic [23:0] ra, rb, x1, x2, x3, input logic et);
    logic [31:0] p;
    rnd(p);
    @(posedge sys_clk);
    req_in <= '{op, cg, c, ra, rb, x1, x2, x3, p[15:0]};
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 100 && !fin; i++)
      @(posedge sys_clk);
    chk("finished", 72'h1, fin);
    chk("latency", 72'h2, lat);
    chk("trap", et, trap_q);
    chk("pointer", p[15:0], res_q.program_pointer);
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    report_and_stop;
  end

  initial
  begin
    logic [31:0] a;
    logic [31:0] b;
    logic [23:0] ra;
    repeat (16) @(posedge sys_clk);
    chk("reset state", 72'h0, {busy, done, trap, res.primary_accumulator});
    reset <= 1'b0;
    chk("trap location", TRAP_LOCATION, trap_location);
    go_op(op_integer_multiply, 1, 5'h17, 24'hfffff8, 0, 0, 24'h8, 0, 0);
    chk("mul c23", 48'hffffffffff80, dbl);
    go_op(op_integer_multiply, 1, 5'h10, 24'hfffff8, 0, 0, 24'h8, 0, 0);
    chk("mul c16", 48'hffffffffc000, dbl);
    go_op(op_integer_multiply, 1, 5'h17, 24'h7, 0, 0, 24'h8, 0, 0);
    chk("mul small", 48'h70, dbl);
    go_op(op_integer_multiply, 0, 5'h03, 24'h5, 0, 0, 24'h3, 0, 0);
    chk("mul default", 48'h1e, dbl);
    go_op(op_integer_multiply, 1, 5'h17, MOST_NEG, 0, 0, 24'h2, 0, 1);
    ce_rand <= 1'b1;
    repeat (40)
    begin
      rnd(a);
      rnd(b);
      // keep the multiplicand within count plus one significant bits
      ra = $signed(a[23:0]) >>> (a[29] ?
        (5'h17 - ((a[28:24] > 5'h17) ? 5'h17 : a[28:24])) : 5'h0);
      go_op(op_integer_multiply, a[29], a[28:24], ra, 0, 0, b[23:0], 0,
        ra == MOST_NEG);
      chk("mul random", mul_exp(ra, b[23:0], a[29], a[28:24]), dbl);
    end
    // float ops always carry count twenty-three
    go_op(op_float_add, 1, 5'h17, 24'h56bc3d, 0, 24'h43, 24'h71afd4, 24'h32, 0);
    chk("fadd", {24'h56bc75, 24'h43, 24'h56bc3d}, flt);
    go_op(op_float_subtract, 1, 5'h17, 24'h56bc3d, 0, 24'h43, 24'h71afd4, 24'h32, 0);
    chk("fsub", {24'h56bc04, 24'h43, 24'h56bc3d}, flt);
    go_op(op_float_add_unnormalized, 1, 5'h17, 24'h100000, 0, 24'h5, 24'h100000, 24'h5, 0);
    chk("ufa", {24'h200000, 24'h5, 24'h100000}, flt);
    go_op(op_float_add, 1, 5'h17, 24'h100000, 0, 24'h5, 24'h100000, 24'h5, 0);
    chk("fadd norm", {24'h400000, 24'h4, 24'h100000}, flt);
    go_op(op_float_add, 1, 5'h17, 24'h0, 0, 24'h50, 24'h56bc3d, 24'h43, 0);
    chk("fadd zero", {24'h56bc3d, 24'h43, 24'h0}, flt);
    go_op(op_float_multiply, 1, 5'h17, 24'h5fffff, 0, 24'h4, 24'h5fffff, 24'h4, 0);
    chk("fmp", {24'h47fffe, 24'h8, 24'h5fffff}, flt);
    go_op(op_float_multiply, 1, 5'h17, 24'h400000, 0, 24'h7fffff, 24'h400000, 24'h7fffff, 1);
    go_op(op_float_subtract, 1, 5'h17, 24'h400000, 0, 24'h1, MOST_NEG, 24'h1, 1);
    go_op(op_integer_divide, 1, 5'h17, 24'h0, 24'he, 0, 24'h3, 0, 0);
    chk("div", 48'h000002000001, dbl);
    go_op(op_integer_divide, 1, 5'h17, 24'h5, 0, 0, 24'h0, 0, 1);
    go_op(op_none, 1, 5'h17, 24'h123456, 0, 24'h9, 24'h77, 0, 0);
    chk("no op", {24'h123456, 24'h9, 24'h77}, flt);
    go_op(op_float_divide, 1, 5'h17, 24'h123456, 0, 24'h9, 24'h77, 0, 0);
    chk("divide absent", {24'h123456, 24'h9, 24'h77}, flt);
    report_and_stop;
  end
endmodule // mfa_multiply_float_arith_unit_tb
`default_nettype wire
